// [src/rtc_time_alarm_value_views.sv]
// pointer-selected clock and alarm value views behind an axi4-lite slave
// Operation
// - clock window pointer 01 shows weekday/hours, 00 shows minutes/seconds
// - alarm window pointer 10 month/day, 01 weekday/hours, 00 min/sec
// - weekday/hours views hold the weekday digit in bits 10-8
// - hours tens digit in bits 5-4, hours units digit in bits 3-0
// - minutes tens digit in bits 14-12, minutes units in 11-8
// - seconds tens digit in bits 6-4, seconds units in 3-0
// - month tens bit in bit 12, month units digit in 11-8
// - day tens digit in bits 5-4, day units digit in 3-0
// - clock hours, month/day and year writes, alarm month/day and alarm hours writes need unlock set
// - unimplemented bits of every view read back as zero
// - clock window pointer 11 shows year tens 7-4 and units 3-0
// - clock window pointer 10 shows month/day in alarm layout
`default_nettype none
module rtc_time_alarm_value_views
   import rtc_view_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      bus_state_t wst;
      bus_state_t rst_st;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] clock_ptr;
      logic [1:0] alarm_ptr;
      logic unlock;
   } ctrl_t;

   // fields are kept apart from the struct: they take no reset value
   logic [15:0] clock_view [4];
   logic [15:0] alarm_view [3];
   ctrl_t r;
   ctrl_t next_r;

   logic do_write;
   logic [15:0] wval;
   logic [15:0] clock_rd;
   logic [15:0] alarm_rd;
   logic [15:0] mask_clk [4];
   logic [15:0] mask_alm [3];
   logic [3:0] clk_we;
   logic [2:0] alm_we;
   logic addr_ok_w;
   logic addr_ok_r;

   assign mask_clk[0] = mask_min_sec;
   assign mask_clk[1] = mask_wkdy_hour;
   assign mask_clk[2] = mask_month_day;
   assign mask_clk[3] = mask_year;
   assign mask_alm[0] = mask_min_sec;
   assign mask_alm[1] = mask_wkdy_hour;
   assign mask_alm[2] = mask_month_day;

   // handshakes drop with the enable: a master must not see a transfer
   // taken or answered while the state cannot move
   assign s_axi_awready = clk_en && (r.wst == bus_idle) && !r.aw_held;
   assign s_axi_wready = clk_en && (r.wst == bus_idle) && !r.w_held;
   assign s_axi_bvalid = clk_en && (r.wst == bus_wresp);
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = clk_en && (r.rst_st == bus_idle);
   assign s_axi_rvalid = clk_en && (r.rst_st == bus_rresp);
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   assign do_write = clk_en && (r.wst == bus_idle) && r.aw_held && r.w_held;
   assign wval = r.w_data[15:0];
   assign addr_ok_w = (r.aw_addr[1:0] == 2'h0) && (r.aw_addr <= off_unlock);
   assign addr_ok_r = (s_axi_araddr[1:0] == 2'h0)
      && (s_axi_araddr <= off_unlock);

   assign clock_rd = clock_view[r.clock_ptr] & mask_clk[r.clock_ptr];
   assign alarm_rd = (r.alarm_ptr == ptr_year) ? 16'h0000 :
      (alarm_view[r.alarm_ptr] & mask_alm[r.alarm_ptr]);

   // per-view write enables; year unlock follows the clock views as well
   always_comb begin
      clk_we = 4'h0;
      alm_we = 3'h0;
      if (do_write && (r.w_strb[1:0] != 2'h0)) begin
         if (r.aw_addr == off_clock_window) begin
            if (r.clock_ptr == ptr_min_sec || r.unlock) begin
               clk_we[r.clock_ptr] = 1'b1;
            end
         end
         if (r.aw_addr == off_alarm_window) begin
            if (r.alarm_ptr == ptr_min_sec || r.unlock) begin
               if (r.alarm_ptr != ptr_year) begin
                  alm_we[r.alarm_ptr] = 1'b1;
               end
            end
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_clk
         always_ff @(posedge mclk) begin
            if (clk_we[gi]) begin
               if (r.w_strb[0]) begin
                  clock_view[gi][7:0] <= wval[7:0] & mask_clk[gi][7:0];
               end
               if (r.w_strb[1]) begin
                  clock_view[gi][15:8] <= wval[15:8] & mask_clk[gi][15:8];
               end
            end
         end
      end
      for (gi = 0; gi < 3; gi++) begin : g_alm
         always_ff @(posedge mclk) begin
            if (alm_we[gi]) begin
               if (r.w_strb[0]) begin
                  alarm_view[gi][7:0] <= wval[7:0] & mask_alm[gi][7:0];
               end
               if (r.w_strb[1]) begin
                  alarm_view[gi][15:8] <= wval[15:8] & mask_alm[gi][15:8];
               end
            end
         end
      end
   endgenerate

   always_comb begin
      next_r = r;
      if (s_axi_awvalid && s_axi_awready) begin
         next_r.aw_held = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_r.w_held = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_r.aw_held = 1'b0;
         next_r.w_held = 1'b0;
         next_r.wst = bus_wresp;
         next_r.bresp = addr_ok_w ? resp_okay : resp_slverr;
         if (addr_ok_w && r.w_strb[0]) begin
            if (r.aw_addr == off_clock_pointer) begin
               next_r.clock_ptr = r.w_data[1:0];
            end
            if (r.aw_addr == off_alarm_pointer) begin
               next_r.alarm_ptr = r.w_data[1:0];
            end
            if (r.aw_addr == off_unlock) begin
               next_r.unlock = r.w_data[0];
            end
         end
      end
      if (r.wst == bus_wresp && s_axi_bready) begin
         next_r.wst = bus_idle;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_r.rst_st = bus_rresp;
         next_r.rresp = addr_ok_r ? resp_okay : resp_slverr;
         unique case (s_axi_araddr)
            off_clock_window: next_r.rdata = {16'h0000, clock_rd};
            off_alarm_window: next_r.rdata = {16'h0000, alarm_rd};
            off_clock_pointer: next_r.rdata = {30'h0, r.clock_ptr};
            off_alarm_pointer: next_r.rdata = {30'h0, r.alarm_ptr};
            off_unlock: next_r.rdata = {31'h0, r.unlock};
            default: next_r.rdata = 32'h00000000;
         endcase
      end
      if (r.rst_st == bus_rresp && s_axi_rready) begin
         next_r.rst_st = bus_idle;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= '{wst: bus_idle, rst_st: bus_idle, aw_held: 1'b0,
            aw_addr: 8'h00, w_held: 1'b0, w_data: 32'h00000000,
            w_strb: 4'h0, bresp: resp_okay, rdata: 32'h00000000,
            rresp: resp_okay, clock_ptr: ptr_reset, alarm_ptr: ptr_reset,
            unlock: unlock_reset};
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   a_locked_hour_write: assert property (@(posedge mclk)
      disable iff (rst) (do_write && !r.unlock
      && r.aw_addr == off_clock_window && r.clock_ptr == ptr_wkdy_hour)
      |=> $stable(clock_view[1]))
      else $error("locked hours write changed view");
   a_clock_read_zero: assert property (@(posedge mclk)
      disable iff (rst) (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == off_clock_window && r.clock_ptr == ptr_wkdy_hour)
      |=> (s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[7:6] == 2'h0))
      else $error("clock hours view unused bits nonzero");
   a_alarm_unused_ptr: assert property (@(posedge mclk)
      disable iff (rst) (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == off_alarm_window && r.alarm_ptr == ptr_year)
      |=> s_axi_rdata == 32'h00000000)
      else $error("alarm pointer 11 read nonzero");
   a_minsec_bits: assert property (@(posedge mclk)
      disable iff (rst) (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == off_alarm_window && r.alarm_ptr == ptr_min_sec)
      |=> (s_axi_rdata[15] == 1'b0 && s_axi_rdata[7] == 1'b0))
      else $error("min/sec unused bits nonzero");
   a_minsec_open: assert property (@(posedge mclk)
      disable iff (rst) (do_write && r.aw_addr == off_clock_window
      && r.w_strb == 4'hF && r.clock_ptr == ptr_min_sec)
      |=> clock_view[0] == ($past(r.w_data[15:0]) & mask_min_sec))
      else $error("minutes/seconds write lost");
   a_month_bits: assert property (@(posedge mclk)
      disable iff (rst) (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == off_clock_window && r.clock_ptr == ptr_month_day)
      |=> (s_axi_rdata[15:13] == 3'h0 && s_axi_rdata[7:6] == 2'h0))
      else $error("month/day unused bits nonzero");
   a_year_bits: assert property (@(posedge mclk)
      disable iff (rst) (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == off_clock_window && r.clock_ptr == ptr_year)
      |=> s_axi_rdata[31:8] == 24'h0)
      else $error("year view upper bits nonzero");
   a_alarm_unlocked: assert property (@(posedge mclk)
      disable iff (rst) (do_write && r.unlock
      && r.aw_addr == off_alarm_window && r.w_strb == 4'hF
      && r.alarm_ptr == ptr_month_day)
      |=> alarm_view[2] == ($past(r.w_data[15:0]) & mask_month_day))
      else $error("unlocked alarm month write lost");
   a_alarm_hour_locked: assert property (@(posedge mclk)
      disable iff (rst) (do_write && !r.unlock
      && r.aw_addr == off_alarm_window && r.alarm_ptr == ptr_wkdy_hour)
      |=> $stable(alarm_view[1]))
      else $error("locked alarm hours write changed view");
   a_alarm_date_locked: assert property (@(posedge mclk)
      disable iff (rst) (do_write && !r.unlock
      && r.aw_addr == off_alarm_window && r.alarm_ptr == ptr_month_day)
      |=> $stable(alarm_view[2]))
      else $error("locked alarm month/day write changed view");
   a_alarm_hour_bits: assert property (@(posedge mclk)
      disable iff (rst) (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == off_alarm_window && r.alarm_ptr == ptr_wkdy_hour)
      |=> (s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[7:6] == 2'h0))
      else $error("alarm hours view unused bits nonzero");
   a_alarm_date_bits: assert property (@(posedge mclk)
      disable iff (rst) (s_axi_arvalid && s_axi_arready && clk_en
      && s_axi_araddr == off_alarm_window && r.alarm_ptr == ptr_month_day)
      |=> (s_axi_rdata[31:13] == 19'h0 && s_axi_rdata[7:6] == 2'h0))
      else $error("alarm month/day unused bits nonzero");
   a_hour_write: assert property (@(posedge mclk)
      disable iff (rst) (do_write && r.unlock && r.w_strb == 4'hF
      && r.aw_addr == off_clock_window && r.clock_ptr == ptr_wkdy_hour)
      |=> clock_view[1] == ($past(r.w_data[15:0]) & mask_wkdy_hour))
      else $error("unlocked hours write lost");
   a_alarm_minsec_open: assert property (@(posedge mclk)
      disable iff (rst) (do_write && r.aw_addr == off_alarm_window
      && r.w_strb == 4'hF && r.alarm_ptr == ptr_min_sec)
      |=> alarm_view[0] == ($past(r.w_data[15:0]) & mask_min_sec))
      else $error("alarm minutes/seconds write lost");
endmodule // rtc_time_alarm_value_views
`default_nettype wire

// [src/rtc_view_pkg.sv]
// constants for the clock and alarm value views
`default_nettype none
package rtc_view_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] off_clock_window = 8'h00;
   localparam logic [7:0] off_clock_pointer = 8'h04;
   localparam logic [7:0] off_alarm_window = 8'h08;
   localparam logic [7:0] off_alarm_pointer = 8'h0C;
   localparam logic [7:0] off_unlock = 8'h10;
   // view pointer codes
   localparam logic [1:0] ptr_min_sec = 2'h0;
   localparam logic [1:0] ptr_wkdy_hour = 2'h1;
   localparam logic [1:0] ptr_month_day = 2'h2;
   localparam logic [1:0] ptr_year = 2'h3;
   // implemented bits per view
   localparam logic [15:0] mask_wkdy_hour = 16'h073F;
   localparam logic [15:0] mask_min_sec = 16'h7F7F;
   localparam logic [15:0] mask_month_day = 16'h1F3F;
   localparam logic [15:0] mask_year = 16'h00FF;
   // reset values of control state
   localparam logic [1:0] ptr_reset = 2'h0;
   localparam logic unlock_reset = 1'b0;
   // axi responses
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_wresp = 2'b01,
      bus_rresp = 2'b10
   } bus_state_t;
endpackage
`default_nettype wire

// [testbench/test_rtc_time_alarm_value_views.sv]
// register-level bench for the clock and alarm value views
`default_nettype none
module test_rtc_time_alarm_value_views;
   import rtc_view_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, clk_en;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb, wmask;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, r;
   int n_errors = 0;
   int comparisons = 0;
   rtc_time_alarm_value_views uut (.mclk(mclk), .rst(rst), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic wrap_up;
      if (n_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // both channels offered together, each dropped once taken
   task automatic bus_write(input logic [7:0] a, input logic [31:0] v,
                            output logic [1:0] res);
      bit done;
      done = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= wmask;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            res = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic bus_read(input logic [7:0] a, output logic [31:0] v,
                           output logic [1:0] res);
      bit done;
      done = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            v = rdata;
            res = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
   endtask
   // all-ones write shows the implemented bits; then a bcd value, then
   // a write with the unlock bit cleared that must stick only if ungated
   task automatic view_test(input logic [7:0] win, input logic [7:0] pof,
      input logic [1:0] p, input logic [15:0] m, input logic [15:0] v,
      input bit gated);
      bus_write(off_unlock, 32'h00000001, r);
      bus_write(pof, {30'h0, p}, r);
      bus_read(pof, d, r);
      check_data(d, {30'h0, p});
      bus_write(win, 32'hFFFFFFFF, r);
      check_resp(r, resp_okay);
      bus_read(win, d, r);
      check_data(d, {16'h0000, m});
      bus_write(win, {16'h0000, v}, r);
      bus_read(win, d, r);
      check_data(d, {16'h0000, v});
      bus_write(off_unlock, 32'h00000000, r);
      bus_write(win, 32'h00000000, r);
      check_resp(r, resp_okay);
      bus_read(win, d, r);
      check_data(d, gated ? {16'h0000, v} : 32'h00000000);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wmask = 4'hF;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      // view contents stay unknown after reset, so only control is read
      bus_read(off_clock_pointer, d, r);
      check_data(d, {30'h0, ptr_reset});
      bus_read(off_alarm_pointer, d, r);
      check_data(d, {30'h0, ptr_reset});
      bus_read(off_unlock, d, r);
      check_data(d, {31'h0, unlock_reset});
      view_test(off_clock_window, off_clock_pointer, ptr_wkdy_hour,
         mask_wkdy_hour, 16'h0623, 1);
      view_test(off_clock_window, off_clock_pointer, ptr_min_sec,
         mask_min_sec, 16'h5947, 0);
      view_test(off_clock_window, off_clock_pointer, ptr_month_day,
         mask_month_day, 16'h1231, 1);
      view_test(off_clock_window, off_clock_pointer, ptr_year,
         mask_year, 16'h0098, 1);
      view_test(off_alarm_window, off_alarm_pointer, ptr_month_day,
         mask_month_day, 16'h0929, 1);
      view_test(off_alarm_window, off_alarm_pointer, ptr_wkdy_hour,
         mask_wkdy_hour, 16'h0019, 1);
      view_test(off_alarm_window, off_alarm_pointer, ptr_min_sec,
         mask_min_sec, 16'h3058, 0);
      // each view keeps its own storage behind the pointer
      bus_write(off_clock_pointer, {30'h0, ptr_wkdy_hour}, r);
      bus_read(off_clock_window, d, r);
      check_data(d, 32'h00000623);
      bus_write(off_alarm_pointer, {30'h0, ptr_month_day}, r);
      bus_read(off_alarm_window, d, r);
      check_data(d, 32'h00000929);
      bus_write(off_alarm_pointer, 32'h00000003, r);
      bus_read(off_alarm_window, d, r);
      check_data(d, 32'h00000000);
      // unmapped and misaligned places
      bus_read(8'h14, d, r);
      check_resp(r, resp_slverr);
      check_data(d, 32'h00000000);
      bus_write(8'h14, 32'hFFFFFFFF, r);
      check_resp(r, resp_slverr);
      bus_read(8'h02, d, r);
      check_resp(r, resp_slverr);
      check_data(d, 32'h00000000);
      // a byte strobe changes only its own half of the view
      bus_write(off_clock_pointer, {30'h0, ptr_min_sec}, r);
      bus_write(off_clock_window, 32'h00005947, r);
      wmask = 4'h2;
      bus_write(off_clock_window, 32'h00000000, r);
      wmask = 4'hF;
      bus_read(off_clock_window, d, r);
      check_data(d, 32'h00000047);
      // a low enable holds the read off until it comes back
      @(posedge mclk);
      clk_en <= 1'b0;
      araddr <= off_clock_pointer;
      arvalid <= 1'b1;
      rready <= 1'b1;
      repeat (4) @(posedge mclk);
      check_data({30'h0, arready, rvalid}, 32'h00000000);
      clk_en <= 1'b1;
      @(posedge mclk);
      arvalid <= 1'b0;
      @(posedge mclk);
      check_data({31'h0, rvalid}, 32'h00000001);
      check_data(rdata, {30'h0, ptr_min_sec});
      rready <= 1'b0;
      // a second reset brings back the control defaults
      bus_write(off_unlock, 32'h00000001, r);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      bus_read(off_alarm_pointer, d, r);
      check_data(d, {30'h0, ptr_reset});
      bus_read(off_unlock, d, r);
      check_data(d, {31'h0, unlock_reset});
      wrap_up();
   end
endmodule // test_rtc_time_alarm_value_views
`default_nettype wire
